// file: rtl/adcp_serial_port.sv
// Purpose: Serial control port and register set of the sampling converter
// Assumes: Pins arrive asynchronously; result_in is on clk_in
// Notes:   Serial clock is sampled, so it must be well below clk_in/4
`timescale 1ns/100ps
module adcp_serial_port #(
   parameter int CAL_EDGES = adcp_pkg::CAL_MCLK_EDGES
) (
   input  wire logic                        clk_in,
   input  wire logic                        rst_b_in,
   input  wire logic                        cal_req_b_in,
   input  wire logic                        master_clock_in,
   input  wire logic                        sleep_b_in,
   input  wire logic                        convert_req_in,
   input  wire logic                        serial_mode_sel_a_in,
   input  wire logic                        serial_mode_sel_b_in,
   input  wire logic                        polarity_in,
   input  wire logic                        sclk_in,
   output logic                             sclk_out,
   output logic                             sclk_oe_out,
   input  wire logic                        frame_b_in,
   output logic                             frame_b_out,
   output logic                             frame_oe_out,
   input  wire logic                        din_in,
   output logic                             din_out,
   output logic                             din_oe_out,
   output logic                             dout_out,
   input  wire logic [adcp_pkg::DATA_W-1:0] result_in,
   output logic                             busy_out,
   output logic                             cal_start_out,
   output logic [2:0]                       cal_type_out,
   output logic                             power_down_out,
   output logic [1:0]                       power_mode_out
);
   import adcp_pkg::*;

   function automatic logic [CAL_IDX_W-1:0] cal_next(
      input logic [CAL_IDX_W-1:0] idx
   );
      cal_next = (idx == CAL_IDX_W'(CAL_REGS - 1)) ? '0 : idx + 1'b1;
   endfunction : cal_next

   // Pin synchronisers
   logic [PINS_W-1:0] meta_q;
   logic [PINS_W-1:0] sync_q;
   logic [PINS_W-1:0] prev_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
         prev_q <= SYNC_RST;
      end else begin
         meta_q <= {cal_req_b_in, master_clock_in, sleep_b_in,
                    convert_req_in, serial_mode_sel_b_in,
                    serial_mode_sel_a_in, polarity_in, sclk_in,
                    frame_b_in, din_in};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Decoded pin state
   wire       pol        = sync_q[PIN_POL];
   wire [1:0] mode       = {sync_q[PIN_SM_B], sync_q[PIN_SM_A]};
   wire       self_clk   = (mode == MODE_SELF_FOUT) ||
                           (mode == MODE_SELF_FIN);
   wire       frame_drv  = (mode == MODE_SELF_FOUT);
   wire       bidir      = (mode == MODE_EXT_BIDIR);
   wire       cal_hold   = ~sync_q[PIN_CAL];
   wire       cal_rise   = sync_q[PIN_CAL] & ~prev_q[PIN_CAL];
   wire       mclk_rise  = sync_q[PIN_MCLK] & ~prev_q[PIN_MCLK];
   wire       conv_rise  = sync_q[PIN_CONV] & ~prev_q[PIN_CONV];
   wire       frame_low  = ~sync_q[PIN_FRAME];
   wire       frame_fall = frame_low & prev_q[PIN_FRAME];
   wire       ext_trail  = (sync_q[PIN_SCLK] == pol) &&
                           (prev_q[PIN_SCLK] != pol);

   // Registers
   adcp_link_e           state_q;
   adcp_link_e           state_d;
   logic [DATA_W-1:0]    ctrl_q;
   logic [DATA_W-1:0]    test_q;
   logic [DATA_W-1:0]    cal_mem [CAL_REGS];
   logic [CAL_IDX_W-1:0] cal_idx_q;
   logic [DATA_W-1:0]    last_res_q;
   logic [WORD_W-1:0]    tx_q;
   logic [WORD_W-1:0]    tx_d;
   logic [WORD_W-1:0]    rx_q;
   logic [BIT_CNT_W-1:0] bit_cnt_q;
   logic [3:0]           div_q;
   logic                 sclk_q;
   logic                 conv_busy_q;
   logic                 cal_busy_q;
   logic [EDGE_CNT_W-1:0] edge_cnt_q;

   // Self-clock generator: toggles every SCLK_HALF cycles in a frame
   wire div_hit   = (div_q == 4'(SCLK_HALF - 1));
   wire gen_run   = self_clk && (state_q == LINK_SHIFT);
   wire gen_trail = gen_run && div_hit && (sclk_q != pol);
   wire trail     = self_clk ? gen_trail : ext_trail;

   // FIFO in the result path
   logic              fifo_in_valid;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data;
   logic              fifo_pop;

   adcp_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .clr_in        (cal_hold),
      .in_valid_in   (fifo_in_valid),
      .in_data_in    (result_in),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_out_valid),
      .out_data_out  (fifo_out_data),
      .out_ready_in  (fifo_pop)
   );

   // Read source select, driven by control bits
   wire [1:0] rd_sel = ctrl_q[CTL_RD_HI:CTL_RD_LO];
   wire [DATA_W-1:0] res_word = fifo_out_valid ? fifo_out_data
                                               : last_res_q;
   wire [DATA_W-1:0] status_word = {2'h0, cal_busy_q, conv_busy_q,
                                    ctrl_q[CTL_PWR_HI:0]};
   logic [WORD_W-1:0] rd_word;

   always_comb begin
      case (rd_sel)
         RS_RESULT: rd_word = {2'h0, res_word};
         RS_TEST:   rd_word = {WT_TEST, test_q};
         RS_CAL:    rd_word = {WT_CAL, cal_mem[cal_idx_q]};
         RS_STATUS: rd_word = {WT_CTRL, status_word};
         default:   rd_word = '0;
      endcase
   end

   // Frame start: self-driven frames only when a new result waits
   wire start_self = frame_drv && fifo_out_valid &&
                     (rd_sel == RS_RESULT);
   wire start      = (state_q == LINK_IDLE) && !cal_hold &&
                     (frame_drv ? start_self : frame_fall);
   // Level-sensitive select: releasing it ends the frame early
   wire abort      = cal_hold ||
                     (!frame_drv && !frame_low &&
                      (state_q == LINK_SHIFT));
   wire last_bit   = trail && (bit_cnt_q == 5'(WORD_W - 1));

   assign fifo_pop = start && (rd_sel == RS_RESULT) && fifo_out_valid;

   always_comb begin
      state_d = state_q;
      case (state_q)
         LINK_IDLE:  if (start) state_d = LINK_SHIFT;
         LINK_SHIFT: if (last_bit) state_d = LINK_LATCH;
         LINK_LATCH: state_d = LINK_IDLE;
         default:    state_d = LINK_IDLE;
      endcase
      if (abort) state_d = LINK_IDLE;
   end

   always_comb begin
      tx_d = tx_q;
      if (start) begin
         tx_d = rd_word;
      end else if (trail && state_q == LINK_SHIFT) begin
         tx_d = {tx_q[WORD_W-2:0], 1'b0};
      end
   end

   // Write decode, only once the word is complete
   wire       latch   = (state_q == LINK_LATCH);
   wire [1:0] wt      = rx_q[WORD_W-1:DATA_W];
   wire       wr_test = latch && (wt == WT_TEST);
   wire       wr_cal  = latch && (wt == WT_CAL);
   wire       wr_ctrl = latch && (wt == WT_CTRL);
   wire       sw_conv = wr_ctrl && rx_q[CTL_CONV];
   wire       sw_cal  = wr_ctrl && rx_q[CTL_CAL_GO];
   wire       rd_cal  = start && (rd_sel == RS_CAL);

   // Conversion refused while the buffer is full
   wire conv_go = (sw_conv || conv_rise) && fifo_in_ready &&
                  !conv_busy_q && !cal_busy_q && !cal_hold;
   wire cal_go  = cal_rise || (sw_cal && !cal_busy_q);
   wire edge_done = mclk_rise && (edge_cnt_q == '0);

   assign fifo_in_valid = conv_busy_q && edge_done && !cal_hold;

   // Link state and shifters
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q   <= LINK_IDLE;
         tx_q      <= '0;
         rx_q      <= '0;
         bit_cnt_q <= '0;
      end else begin
         state_q <= state_d;
         tx_q    <= tx_d;
         if (start) begin
            bit_cnt_q <= '0;
         end else if (trail && state_q == LINK_SHIFT) begin
            rx_q      <= {rx_q[WORD_W-2:0], sync_q[PIN_DIN]};
            bit_cnt_q <= bit_cnt_q + 1'b1;
         end
      end
   end

   // Serial clock generator, idles at the polarity level
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         div_q  <= '0;
         sclk_q <= 1'b0;
      end else if (!gen_run) begin
         div_q  <= '0;
         sclk_q <= pol;
      end else if (div_hit) begin
         div_q  <= '0;
         sclk_q <= ~sclk_q;
      end else begin
         div_q  <= div_q + 1'b1;
      end
   end

   // Register file; calibrate pin low returns control and cal index to defaults, test register kept
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_q     <= CTRL_RST;
         test_q     <= TEST_RST;
         cal_idx_q  <= '0;
         last_res_q <= '0;
      end else if (cal_hold) begin
         ctrl_q    <= CTRL_RST;
         cal_idx_q <= '0;
      end else begin
         if (wr_ctrl) begin
            // Pulse bits are acted on, not kept
            ctrl_q <= rx_q[DATA_W-1:0] &
                      ~(DATA_W'(1) << CTL_CONV) &
                      ~(DATA_W'(1) << CTL_CAL_GO);
         end
         if (wr_test) test_q <= rx_q[DATA_W-1:0];
         if (wr_ctrl) begin
            cal_idx_q <= '0;
         end else if (wr_cal || rd_cal) begin
            cal_idx_q <= cal_next(cal_idx_q);
         end
         if (fifo_pop) last_res_q <= fifo_out_data;
      end
   end

   // Calibration store survives the calibrate pin
   always_ff @(posedge clk_in) begin
      if (wr_cal && !cal_hold) begin
         cal_mem[cal_idx_q] <= rx_q[DATA_W-1:0];
      end
   end

   // Conversion and calibration timing in master clock edges
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         conv_busy_q <= 1'b0;
         cal_busy_q  <= 1'b0;
         edge_cnt_q  <= '0;
      end else if (cal_hold) begin
         conv_busy_q <= 1'b0;
         cal_busy_q  <= 1'b0;
         edge_cnt_q  <= '0;
      end else if (cal_go) begin
         conv_busy_q <= 1'b0;
         cal_busy_q  <= 1'b1;
         edge_cnt_q  <= EDGE_CNT_W'(CAL_EDGES - 1);
      end else if (conv_go) begin
         conv_busy_q <= 1'b1;
         edge_cnt_q  <= EDGE_CNT_W'(CONV_MCLK_EDGES - 1);
      end else if (conv_busy_q || cal_busy_q) begin
         if (edge_done) begin
            conv_busy_q <= 1'b0;
            cal_busy_q  <= 1'b0;
         end else if (mclk_rise) begin
            edge_cnt_q <= edge_cnt_q - 1'b1;
         end
      end
   end

   // Output flops
   wire in_frame = (state_d == LINK_SHIFT);
   wire sleeping = ~sync_q[PIN_SLEEP];

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sclk_out       <= 1'b0;
         sclk_oe_out    <= 1'b0;
         frame_b_out    <= 1'b1;
         frame_oe_out   <= 1'b0;
         din_out        <= 1'b0;
         din_oe_out     <= 1'b0;
         dout_out       <= 1'b0;
         busy_out       <= 1'b0;
         cal_start_out  <= 1'b0;
         cal_type_out   <= '0;
         power_down_out <= 1'b0;
         power_mode_out <= '0;
      end else begin
         sclk_out     <= gen_run ? sclk_q : pol;
         sclk_oe_out  <= self_clk;
         frame_b_out  <= ~(frame_drv && in_frame);
         frame_oe_out <= frame_drv;
         din_out      <= bidir && in_frame && tx_d[WORD_W-1];
         din_oe_out   <= bidir && in_frame;
         dout_out     <= !bidir && in_frame && tx_d[WORD_W-1];
         busy_out     <= conv_busy_q || cal_busy_q || cal_go;
         cal_start_out <= cal_go && !cal_hold;
         if (cal_go) begin
            // Pin start is full self-cal; soft start uses the word in flight
            cal_type_out <= cal_rise ? 3'h0
                          : rx_q[CTL_CALT_HI:CTL_CALT_LO];
         end
         // Full power-down waits for conversion or calibration to end
         power_down_out <= sleeping && !conv_busy_q &&
                           !cal_busy_q;
         power_mode_out <= sleeping ? ctrl_q[CTL_PWR_HI:CTL_PWR_LO]
                                    : 2'h0;
      end
   end
endmodule : adcp_serial_port

// file: rtl/adcp_pkg.sv
// Purpose: Constants and types for the converter serial control port
// Assumes: clk_in at 20 MHz, all pins synchronised before use
// Notes:   Field positions follow the 14-bit control word layout
//
// How it works
// - Two mode select pins together pick the serial interface mode.
// - Calibrate pin low resets logic; its rising edge starts calibration.
// - Calibrate request aborts any conversion or serial transfer under way.
// - Read data leaves as one 16-bit word on the serial output, or on the serial input in bidirectional mode.
// - Serial input is input only or bidirectional, by mode.
// - Master clock edges time conversions and calibrations.
// - Device drives serial clock in self-clocking modes, host otherwise.
// - Serial clock idles at polarity pin level; active edge follows it.
// - Frame line is active-low level input or device-driven frame output.
// - After reset defaults apply; works as read-only converter.
// - Power-down and self-calibration remain available without writes.
// - Power variants, calibration types, software convert only via writes.
// - Control write-only; result, status read-only; test, 10 cal read/write.
// - Top two write bits pick none, test, calibration or control.
// - Write data lands only after all sixteen bits arrive.
// - Two control bits select the source of every later read.
package adcp_pkg;
   localparam int WORD_W     = 16;
   localparam int DATA_W     = 14;
   localparam int CAL_REGS   = 10;
   localparam int CAL_IDX_W  = 4;
   localparam int FIFO_DEPTH = 32;
   localparam int BIT_CNT_W  = 5;
   localparam int PINS_W     = 10;

   // Write target and read source codes
   localparam logic [1:0] WT_NONE   = 2'h0;
   localparam logic [1:0] WT_TEST   = 2'h1;
   localparam logic [1:0] WT_CAL    = 2'h2;
   localparam logic [1:0] WT_CTRL   = 2'h3;
   localparam logic [1:0] RS_RESULT = 2'h0;
   localparam logic [1:0] RS_TEST   = 2'h1;
   localparam logic [1:0] RS_CAL    = 2'h2;
   localparam logic [1:0] RS_STATUS = 2'h3;

   // Serial modes from {mode_sel_b, mode_sel_a}
   localparam logic [1:0] MODE_SELF_FOUT = 2'h0;
   localparam logic [1:0] MODE_SELF_FIN  = 2'h1;
   localparam logic [1:0] MODE_EXT_CS    = 2'h2;
   localparam logic [1:0] MODE_EXT_BIDIR = 2'h3;

   // Control word fields
   localparam int CTL_PWR_HI = 9;
   localparam int CTL_PWR_LO = 8;
   localparam int CTL_RD_HI  = 7;
   localparam int CTL_RD_LO  = 6;
   localparam int CTL_CONV   = 4;
   localparam int CTL_CALT_HI = 3;
   localparam int CTL_CALT_LO = 1;
   localparam int CTL_CAL_GO = 0;

   // Synchroniser bit positions
   localparam int PIN_CAL   = 9;
   localparam int PIN_MCLK  = 8;
   localparam int PIN_SLEEP = 7;
   localparam int PIN_CONV  = 6;
   localparam int PIN_SM_B  = 5;
   localparam int PIN_SM_A  = 4;
   localparam int PIN_POL   = 3;
   localparam int PIN_SCLK  = 2;
   localparam int PIN_FRAME = 1;
   localparam int PIN_DIN   = 0;

   localparam logic [PINS_W-1:0] SYNC_RST = 10'h3ff;
   localparam logic [DATA_W-1:0] CTRL_RST = 14'h0000;
   localparam logic [DATA_W-1:0] TEST_RST = 14'h0000;

   // Timing
   localparam int CLK_HZ          = 20_000_000;
   localparam int MCLK_NOM_HZ     = 7_000_000;
   localparam int SCLK_HZ         = 2_000_000;
   localparam int SCLK_HALF       = CLK_HZ / (2 * SCLK_HZ);
   localparam int CONV_MCLK_EDGES = 20;
   localparam int CAL_MCLK_EDGES  = 2000;
   localparam int EDGE_CNT_W      = 12;

   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_SHIFT,
      LINK_LATCH
   } adcp_link_e;
endpackage : adcp_pkg

// file: rtl/adcp_fifo.sv
// Purpose: Result buffer between conversion and serial read
// Assumes: Single clock, valid/ready on both sides
// Notes:   Synchronous clear flushes contents
`timescale 1ns/100ps
module adcp_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             clr_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid_in & in_ready_out;
   wire              pop  = out_valid_out & out_ready_in;

   assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out  = mem[rd_q];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_q] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (clr_in) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : adcp_fifo

// file: verif/adcp_serial_port_chk.sv
// Purpose: Port-level assertions for the serial control port
// Assumes: Mode and polarity pins change only between frames
// Notes:   Five- and six-cycle windows cover the pin synchronisers
`timescale 1ns/100ps
module adcp_serial_port_chk #(
   parameter int CAL_EDGES = 8
) (
   input wire logic       clk_in,
   input wire logic       rst_b_in,
   input wire logic       cal_req_b_in,
   input wire logic       sleep_b_in,
   input wire logic       serial_mode_sel_a_in,
   input wire logic       serial_mode_sel_b_in,
   input wire logic       polarity_in,
   input wire logic       frame_b_in,
   input wire logic       sclk_out,
   input wire logic       sclk_oe_out,
   input wire logic       frame_b_out,
   input wire logic       frame_oe_out,
   input wire logic       dout_out,
   input wire logic       busy_out,
   input wire logic       cal_start_out,
   input wire logic       power_down_out,
   input wire logic [1:0] power_mode_out
);
   wire logic [1:0] m = {serial_mode_sel_b_in, serial_mode_sel_a_in};
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   property p_sclk_dir; $stable(m)[*5] |-> sclk_oe_out == !m[1]; endproperty
   a_sclk_dir: assert property (p_sclk_dir) else $error("sclk dir");
   property p_frame_dir;
      $stable(m)[*5] |-> frame_oe_out == (m == 2'h0);
   endproperty
   a_frame_dir: assert property (p_frame_dir) else $error("frame dir");
   property p_sclk_idle;
      ($stable(polarity_in) && frame_oe_out && frame_b_out)[*6]
         |-> sclk_out == polarity_in;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("sclk idle");
   property p_dout_idle; (!frame_oe_out && frame_b_in)[*6] |-> !dout_out;
   endproperty
   a_dout_idle: assert property (p_dout_idle) else $error("dout idle");
   property p_cal_hold;
      (!cal_req_b_in)[*5] |-> !busy_out && !dout_out && !cal_start_out;
   endproperty
   a_cal_hold: assert property (p_cal_hold) else $error("cal hold");
   property p_cal_go; $rose(cal_req_b_in) |-> ##[1:6] cal_start_out;
   endproperty
   a_cal_go: assert property (p_cal_go) else $error("cal start");
   property p_busy_min; $rose(busy_out) |-> busy_out[*8]; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy short");
   property p_sleep; (!sleep_b_in && !busy_out)[*5] |-> power_down_out;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no power down");
   property p_awake;
      sleep_b_in[*5] |-> !power_down_out && power_mode_out == 2'h0;
   endproperty
   a_awake: assert property (p_awake) else $error("awake power");
   c_cal: cover property (cal_start_out);
   c_frame: cover property ($fell(frame_b_in) ##[1:200] $rose(frame_b_in));
   c_conv: cover property ($fell(busy_out));
endmodule : adcp_serial_port_chk
bind adcp_serial_port adcp_serial_port_chk #(.CAL_EDGES(CAL_EDGES))
   u_adcp_serial_port_chk (.clk_in, .rst_b_in, .cal_req_b_in, .sleep_b_in,
   .serial_mode_sel_a_in, .serial_mode_sel_b_in, .polarity_in, .frame_b_in,
   .sclk_out, .sclk_oe_out, .frame_b_out, .frame_oe_out, .dout_out,
   .busy_out, .cal_start_out, .power_down_out, .power_mode_out);

// file: verif/adcp_host_model.sv
// Purpose: Host serial port for the external-clock modes
// Assumes: Device samples on the return-to-idle edge
// Notes:   Half period of 4 clk gives the 400 ns link clock
`timescale 1ns/100ps
module adcp_host_model (
   input  wire logic clk_in,
   input  wire logic polarity_in,
   input  wire logic rd_oe_in,
   input  wire logic rd_pin_in,
   input  wire logic dout_in,
   output logic      sclk_out,
   output logic      frame_b_out,
   output logic      din_out
);
   initial {sclk_out, frame_b_out, din_out} = 3'b010;
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step
   // Fewer than 16 bits makes an aborted frame
   task automatic xfer(input logic [15:0] wr, input int n,
                       output logic [15:0] rd);
      rd = 16'h0000;
      sclk_out = polarity_in;
      frame_b_out = 1'b0;
      step(8);
      for (int i = 15; i > 15 - n; i--) begin
         din_out = wr[i];
         sclk_out = !polarity_in;
         step(4);
         rd = {rd[14:0], rd_oe_in ? rd_pin_in : dout_in};
         sclk_out = polarity_in;
         step(4);
      end
      step(8);
      frame_b_out = 1'b1;
      din_out = 1'b0;
      step(8);
   endtask : xfer
endmodule : adcp_host_model

// file: verif/test_adc_serial_control_port.sv
// Purpose: Self-checking bench for the converter serial control port
// Assumes: Host clocks the link in modes 10 and 11, the device in mode 00
// Notes:   Calibration shortened to 8 master clock edges
`timescale 1ns/100ps
module test_adc_serial_control_port;
   import adcp_pkg::*;
   logic        clk_in = 0, rst_b_in = 0, cal_req_b_in = 1, sleep_b_in = 1;
   logic        master_clock_in = 0, convert_req_in = 0, polarity_in = 0;
   logic        serial_mode_sel_a_in = 0, serial_mode_sel_b_in = 1;
   logic        sclk_in, frame_b_in, host_din, sclk_out, sclk_oe_out;
   logic        frame_b_out, frame_oe_out, din_out, din_oe_out, dout_out;
   logic        busy_out, cal_start_out, power_down_out;
   logic [2:0]  cal_type_out;
   logic [1:0]  power_mode_out;
   logic [13:0] result_in = 14'h0000, tv;
   logic [13:0] cal_m [10];
   logic [13:0] res_q [$];
   logic [15:0] rd;
   int          seed = 32'h88d9, fails = 0, checked = 0, starts = 0, cyc, n0;
   wire logic   din_in = din_oe_out ? din_out : host_din;
   initial forever #25 clk_in = !clk_in;
   initial forever #70 master_clock_in = !master_clock_in;
   always @(posedge clk_in) if (cal_start_out === 1'b1) starts++;
   adcp_serial_port #(.CAL_EDGES(8)) u_adcp_serial_port (.clk_in, .rst_b_in,
      .cal_req_b_in, .master_clock_in, .sleep_b_in, .convert_req_in,
      .serial_mode_sel_a_in, .serial_mode_sel_b_in, .polarity_in, .sclk_in,
      .sclk_out, .sclk_oe_out, .frame_b_in, .frame_b_out, .frame_oe_out,
      .din_in, .din_out, .din_oe_out, .dout_out, .result_in, .busy_out,
      .cal_start_out, .cal_type_out, .power_down_out, .power_mode_out);
   adcp_host_model u_adcp_host_model (.clk_in, .polarity_in,
      .rd_oe_in(din_oe_out), .rd_pin_in(din_in), .dout_in(dout_out),
      .sclk_out(sclk_in), .frame_b_out(frame_b_in), .din_out(host_din));
   task automatic check(input string what, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done;
      $display("checked %0d, fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step
   task automatic xf(input logic [15:0] w, input int n);
      u_adcp_host_model.xfer(w, n, rd);
   endtask : xf
   task automatic wait_busy(input logic lvl, input int lim, input bit must);
      for (cyc = 0; busy_out !== lvl && cyc < lim; cyc++) step(1);
      if (must && cyc == lim) begin
         fails++;
         test_done();
      end
   endtask : wait_busy
   // A full buffer refuses the request, so busy stays low
   task automatic convert(input bit room);
      result_in = 14'($random(seed));
      convert_req_in = 1'b1;
      step(4);
      convert_req_in = 1'b0;
      wait_busy(1'b1, 10, room);
      check("conv start", 16'(busy_out), 16'(room));
      if (room) begin
         res_q.push_back(result_in);
         wait_busy(1'b0, 300, 1'b1);
         check("conv time", 16'(cyc > 40 && cyc < 62), 16'h1);
      end
   endtask : convert
   // Mode 00: the device clocks its own frame; take dout on the leading edge
   task automatic self_rd;
      logic s = 1'b0;
      rd = 16'h0000;
      for (cyc = 0; frame_b_out !== 1'b0 && cyc < 400; cyc++) step(1);
      check("self frame", 16'(cyc < 400), 16'h1);
      for (int i = 0; frame_b_out === 1'b0 && i < 400; i++) begin
         if (sclk_out === 1'b1 && !s) rd = {rd[14:0], dout_out};
         s = sclk_out;
         step(1);
      end
      check("self frame end", 16'(frame_b_out), 16'h1);
   endtask : self_rd
   initial begin
      repeat (6) @(posedge clk_in);
      #1 rst_b_in = 1'b1;
      for (int m = 0; m < 8; m++) begin
         {serial_mode_sel_b_in, serial_mode_sel_a_in, polarity_in} = 3'(m);
         step(6);
         check("sclk dir", 16'(sclk_oe_out), 16'(m < 4));
         check("frame dir", 16'(frame_oe_out), 16'(m < 2));
         if (m < 4) check("sclk idle", 16'(sclk_out), 16'(m % 2));
      end
      {serial_mode_sel_b_in, serial_mode_sel_a_in, polarity_in} = 3'h4;
      for (int i = 0; i < 33; i++) convert(i < 32);
      for (int i = 0; i < 32; i++) begin
         xf(16'h0000, 16);
         check("result", rd, {RS_RESULT, res_q.pop_front()});
      end
      tv = 14'($random(seed));
      xf({WT_CTRL, 14'h0040}, 16);
      xf({WT_NONE, tv}, 16);
      check("test read", rd, {RS_TEST, TEST_RST});
      xf({WT_CTRL, 14'h00c0}, 8);
      {serial_mode_sel_b_in, serial_mode_sel_a_in, polarity_in} = 3'h7;
      step(6);
      xf(16'h0000, 16);
      check("bidir read", rd, {RS_TEST, TEST_RST});
      {serial_mode_sel_b_in, serial_mode_sel_a_in, polarity_in} = 3'h4;
      step(6);
      xf({WT_CTRL, 14'h0000}, 16);
      for (int i = 0; i < 10; i++) begin
         cal_m[i] = 14'($random(seed));
         xf({WT_CAL, cal_m[i]}, 16);
      end
      xf({WT_CTRL, 14'h0080}, 16);
      for (int i = 0; i < 10; i++) begin
         xf(16'h0000, 16);
         check("cal read", rd, {RS_CAL, cal_m[i]});
      end
      xf({WT_CTRL, 14'h03c0}, 16);
      xf(16'h0000, 16);
      check("status", rd, {RS_STATUS, 14'h03c0});
      sleep_b_in = 1'b0;
      step(6);
      check("sleep", 16'({power_down_out, power_mode_out}), 16'h7);
      n0 = starts;
      xf({WT_CTRL, 14'h000b}, 16);
      wait_busy(1'b0, 300, 1'b1);
      step(6);
      check("soft cal", 16'(starts - n0), 16'h1);
      check("cal type", 16'(cal_type_out), 16'h5);
      check("sleep mode", 16'({power_down_out, power_mode_out}),
            16'h4);
      n0 = starts;
      fork
         xf({WT_CAL, ~cal_m[0]}, 16);
         begin
            step(60);
            cal_req_b_in = 1'b0;
            step(6);
            cal_req_b_in = 1'b1;
         end
      join
      wait_busy(1'b0, 300, 1'b1);
      check("pin cal", 16'(starts - n0), 16'h1);
      check("pin cal type", 16'(cal_type_out), 16'h0);
      xf({WT_CTRL, 14'h0080}, 16);
      xf(16'h0000, 16);
      check("aborted write", rd, {RS_CAL, cal_m[0]});
      xf({WT_CTRL, 14'h0000}, 16);
      {serial_mode_sel_b_in, serial_mode_sel_a_in, polarity_in} = 3'h0;
      step(6);
      convert(1'b1);
      self_rd();
      check("self read", rd, {RS_RESULT, res_q.pop_front()});
      test_done();
   end
endmodule : test_adc_serial_control_port
